// ### core/line_input_ctrl_pkg.sv
// constants for the left line-input routing and power registers
// assumes one 100 MHz clock, plain register port with byte-wide data
// Functional notes
// - line one bit 7 picks differential wiring
// - line one codes 0-8 attenuate and connect
// - line one code 15 disconnects, reset value
// - line one bit 2 powers converter up
// - line one bits 1-0 pick soft-step rate
// - line two bit 7 picks differential wiring
// - line two codes 0-8 attenuate and connect
// - line two code 15 disconnects, reset value
// - line two bit 2 enables weak bias
// - line two bits 1-0 read zero
// - 7-bit gain, half dB, saturates 59.5
package line_input_ctrl_pkg;
  localparam logic [7:0] LINE_ONE_ADDR = 8'h13;
  localparam logic [7:0] LINE_TWO_ADDR = 8'h14;
  localparam logic [7:0] GAIN_TARGET_ADDR = 8'h0F;
  localparam logic [7:0] GAIN_STATUS_ADDR = 8'h30;
  localparam logic [7:0] FLAG_ADDR = 8'h31;
  localparam int DIFF_BIT = 7;
  localparam int LEVEL_MSB = 6;
  localparam int LEVEL_LSB = 3;
  localparam int POWER_BIT = 2;
  localparam int BIAS_BIT = 2;
  localparam int STEP_MSB = 1;
  localparam int STEP_LSB = 0;
  localparam int SETTLED_BIT = 7;
  localparam logic [7:0] LINE_ONE_RST = 8'h78;
  localparam logic [7:0] LINE_TWO_RST = 8'h78;
  localparam logic [7:0] LINE_TWO_WMASK = 8'hFC;
  localparam logic [3:0] LEVEL_MAX = 4'h8;
  localparam logic [3:0] LEVEL_DISCONNECT = 4'hF;
  localparam logic [1:0] STEP_EVERY = 2'h0;
  localparam logic [1:0] STEP_EVERY_TWO = 2'h1;
  localparam logic [6:0] GAIN_RST = 7'h00;
  localparam logic [6:0] GAIN_MAX = 7'h77;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam int CLK_HZ = 100_000_000;
  localparam int SAMPLE_HZ = 48_000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYCLES - 1);
  typedef enum logic [0:0] {STEP_IDLE, STEP_RUN} step_state_t;
endpackage

// ### core/level_decode.sv
// one line input's level code turned into mixer connect and attenuation
// assumes code comes from a register on the same clock
`timescale 1ns/1ps
module level_decode
  import line_input_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // level code
  input wire logic [3:0] level_in,
  // decoded controls
  output logic connect_out,
  output logic [4:0] atten_out,
  output logic reserved_out
);
  logic connect_d;
  // attenuation in half-dB units, three per code
  logic [4:0] atten_d;

  assign reserved_out = (level_in > LEVEL_MAX) && (level_in != LEVEL_DISCONNECT);

  always_comb
  begin
    connect_d = (level_in <= LEVEL_MAX);
    atten_d = 5'({1'b0, level_in}) + 5'({level_in, 1'b0});
    // disconnect code; reserved codes also left open
    if (!connect_d)
    begin
      atten_d = 5'h00;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      connect_out <= 1'b0;
      atten_out <= 5'h00;
    end
    else
    begin
      connect_out <= connect_d;
      atten_out <= atten_d;
    end
  end
endmodule

// ### core/gain_stepper.sv
// applied gain walking toward the programmed target
// assumes sample_tick_in is a one-cycle pulse per sample period
`timescale 1ns/1ps
module gain_stepper
  import line_input_ctrl_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic sample_tick_in,
  input wire logic [1:0] mode_in,
  input wire logic [6:0] target_in,
  // applied gain
  output logic [6:0] gain_out,
  output logic settled_out
);
  step_state_t state_q;
  logic half_q;
  logic step_en;

  assign step_en = sample_tick_in && ((mode_in == STEP_EVERY) || ((mode_in == STEP_EVERY_TWO) && half_q));
  assign settled_out = (state_q == STEP_IDLE);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      half_q <= 1'b0;
    else if (sample_tick_in)
      half_q <= ~half_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      gain_out <= GAIN_RST;
      state_q <= STEP_IDLE;
    end
    else if (mode_in > STEP_EVERY_TWO)
    begin
      gain_out <= target_in;
      state_q <= STEP_IDLE;
    end
    else
    begin
      case (state_q)
        STEP_IDLE:
          if (gain_out != target_in)
            state_q <= STEP_RUN;
        STEP_RUN:
          if (gain_out == target_in)
            state_q <= STEP_IDLE;
          else if (step_en)
            gain_out <= (gain_out < target_in) ? gain_out + 7'h01 : gain_out - 7'h01;
        default:
          state_q <= STEP_IDLE;
      endcase
    end
  end
endmodule

// ### core/left_adc_line_input_control.sv
// register bank routing the two left line inputs into the left mixer
// assumes register port and all outputs share SYS_CLK_IN; analog side samples the outputs
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module left_adc_line_input_control
  import line_input_ctrl_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // first left line input
  output logic FIRST_LEFT_LINE_DIFF_OUT,
  output logic FIRST_LEFT_LINE_CONNECT_OUT,
  output logic [4:0] FIRST_LEFT_LINE_ATTEN_OUT,
  output logic FIRST_LEFT_LINE_BIAS_OUT,
  // second left line input
  output logic SECOND_LEFT_LINE_DIFF_OUT,
  output logic SECOND_LEFT_LINE_CONNECT_OUT,
  output logic [4:0] SECOND_LEFT_LINE_ATTEN_OUT,
  output logic SECOND_LEFT_LINE_BIAS_OUT,
  // converter channel
  output logic ADC_POWER_UP_OUT,
  output logic WEAK_BIAS_EN_OUT,
  output logic [6:0] PGA_GAIN_OUT,
  output logic GAIN_SETTLED_OUT,
  output logic SAMPLE_TICK_OUT
);
  // register storage
  logic [7:0] line_one_q;
  logic [7:0] line_two_q;
  logic [6:0] gain_target_q;
  logic [2:0] flags_q;
  logic [2:0] flags_d;

  // write decode
  logic wr_line_one;
  logic wr_line_two;
  logic wr_gain;
  logic wr_flags;

  // read path
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // sample divider
  logic [11:0] div_q;
  logic tick_q;

  // per-input views
  logic [1:0][3:0] level_codes;
  logic [1:0] connect_w;
  logic [1:0][4:0] atten_w;
  logic [1:0] reserved_w;
  logic [1:0] bias_d;
  logic [1:0] bias_q;

  // decoded outputs
  logic diff_one_q;
  logic diff_two_q;
  logic power_q;
  logic weak_bias_q;

  // gain stepping
  logic [6:0] gain_sat;
  logic [1:0] step_mode;
  logic [6:0] gain_applied;
  logic settled_w;

  always_comb
  begin
    wr_line_one = 1'b0;
    wr_line_two = 1'b0;
    wr_gain = 1'b0;
    wr_flags = 1'b0;
    if (REG_WR_IN)
    begin
      if (REG_ADDR_IN == LINE_ONE_ADDR)
        wr_line_one = 1'b1;
      else if (REG_ADDR_IN == LINE_TWO_ADDR)
        wr_line_two = 1'b1;
      else if (REG_ADDR_IN == GAIN_TARGET_ADDR)
        wr_gain = 1'b1;
      else if (REG_ADDR_IN == FLAG_ADDR)
        wr_flags = 1'b1;
    end
  end

  // wiring, level, power, rate stored together
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      line_one_q <= LINE_ONE_RST;
    else if (wr_line_one)
      line_one_q <= REG_WDATA_IN;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      line_two_q <= LINE_TWO_RST;
    else if (wr_line_two)
      line_two_q <= REG_WDATA_IN & LINE_TWO_WMASK;
  end

  // codes past the top entry saturate
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      gain_target_q <= GAIN_RST;
    else if (wr_gain)
      gain_target_q <= (REG_WDATA_IN[6:0] > GAIN_MAX) ? GAIN_MAX : REG_WDATA_IN[6:0];
  end

  // sticky misuse flags; a fresh event beats a clear in the same cycle
  always_comb
  begin
    flags_d = flags_q;
    if (wr_flags)
      flags_d = flags_q & ~REG_WDATA_IN[2:0];
    if (wr_line_one && reserved_w[0] == 1'b0
        && (REG_WDATA_IN[LEVEL_MSB:LEVEL_LSB] > LEVEL_MAX)
        && (REG_WDATA_IN[LEVEL_MSB:LEVEL_LSB] != LEVEL_DISCONNECT))
      flags_d[0] = 1'b1;
    if (wr_line_two
        && (REG_WDATA_IN[LEVEL_MSB:LEVEL_LSB] > LEVEL_MAX)
        && (REG_WDATA_IN[LEVEL_MSB:LEVEL_LSB] != LEVEL_DISCONNECT))
      flags_d[1] = 1'b1;
    if (wr_line_two && (REG_WDATA_IN[STEP_MSB:STEP_LSB] != 2'h0))
      flags_d[2] = 1'b1;
    // a level already reserved keeps its flag raised
    if (reserved_w[0])
      flags_d[0] = 1'b1;
    if (reserved_w[1])
      flags_d[1] = 1'b1;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      flags_q <= FLAGS_RST;
    else
      flags_q <= flags_d;
  end

  // sample-rate divider; idle while the converter is down to save power
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end
    else if (!power_q)
    begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end
    else if (div_q == SAMPLE_LAST)
    begin
      div_q <= 12'h000;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  assign level_codes[0] = line_one_q[LEVEL_MSB:LEVEL_LSB];
  assign level_codes[1] = line_two_q[LEVEL_MSB:LEVEL_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_input
      level_decode u_level
      (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .level_in(level_codes[gi]),
        .connect_out(connect_w[gi]),
        .atten_out(atten_w[gi]),
        .reserved_out(reserved_w[gi])
      );
      // bias only unselected inputs
      // decoded from the stored code so it lines up with the registered connect output
      assign bias_d[gi] = line_two_q[BIAS_BIT] && !(level_codes[gi] <= LEVEL_MAX);
    end
  endgenerate

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      bias_q <= 2'h0;
    else
      bias_q <= bias_d;
  end

  // wiring mode and power, registered outputs
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      diff_one_q <= 1'b0;
      diff_two_q <= 1'b0;
      power_q <= 1'b0;
      weak_bias_q <= 1'b0;
    end
    else
    begin
      diff_one_q <= line_one_q[DIFF_BIT];
      diff_two_q <= line_two_q[DIFF_BIT];
      power_q <= line_one_q[POWER_BIT];
      weak_bias_q <= line_two_q[BIAS_BIT];
    end
  end

  // no samples flow while powered down, so gain changes land at once
  assign step_mode = power_q ? line_one_q[STEP_MSB:STEP_LSB] : 2'h3;
  assign gain_sat = gain_target_q;

  gain_stepper u_stepper
  (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .sample_tick_in(tick_q),
    .mode_in(step_mode),
    .target_in(gain_sat),
    .gain_out(gain_applied),
    .settled_out(settled_w)
  );

  always_comb
  begin
    rdata_d = 8'h00;
    if (REG_ADDR_IN == LINE_ONE_ADDR)
      rdata_d = line_one_q;
    else if (REG_ADDR_IN == LINE_TWO_ADDR)
      rdata_d = line_two_q & LINE_TWO_WMASK;
    else if (REG_ADDR_IN == GAIN_TARGET_ADDR)
      rdata_d = {1'b0, gain_target_q};
    else if (REG_ADDR_IN == GAIN_STATUS_ADDR)
      rdata_d = {settled_w, gain_applied};
    else if (REG_ADDR_IN == FLAG_ADDR)
      rdata_d = {5'h00, flags_q};
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
      rdata_q <= 8'h00;
    else if (REG_RD_IN)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end

  assign REG_RDATA_OUT = rdata_q;
  assign FIRST_LEFT_LINE_DIFF_OUT = diff_one_q;
  assign FIRST_LEFT_LINE_CONNECT_OUT = connect_w[0];
  assign FIRST_LEFT_LINE_ATTEN_OUT = atten_w[0];
  assign FIRST_LEFT_LINE_BIAS_OUT = bias_q[0];
  assign SECOND_LEFT_LINE_DIFF_OUT = diff_two_q;
  assign SECOND_LEFT_LINE_CONNECT_OUT = connect_w[1];
  assign SECOND_LEFT_LINE_ATTEN_OUT = atten_w[1];
  assign SECOND_LEFT_LINE_BIAS_OUT = bias_q[1];
  assign ADC_POWER_UP_OUT = power_q;
  assign WEAK_BIAS_EN_OUT = weak_bias_q;
  assign PGA_GAIN_OUT = gain_applied;
  assign GAIN_SETTLED_OUT = settled_w;
  assign SAMPLE_TICK_OUT = tick_q;
endmodule

// ### verif/left_adc_line_input_control_monitor.sv
// port-level assertions for the left line-input register bank
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module left_adc_line_input_control_monitor
  import line_input_ctrl_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  // line inputs
  input wire logic FIRST_LEFT_LINE_CONNECT_OUT,
  input wire logic [4:0] FIRST_LEFT_LINE_ATTEN_OUT,
  input wire logic FIRST_LEFT_LINE_BIAS_OUT,
  input wire logic SECOND_LEFT_LINE_CONNECT_OUT,
  input wire logic [4:0] SECOND_LEFT_LINE_ATTEN_OUT,
  // converter channel
  input wire logic ADC_POWER_UP_OUT,
  input wire logic WEAK_BIAS_EN_OUT,
  input wire logic [6:0] PGA_GAIN_OUT,
  input wire logic GAIN_SETTLED_OUT,
  input wire logic SAMPLE_TICK_OUT
);
  default clocking mon_cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  logic wr_one;
  logic wr_two;
  assign wr_one = REG_WR_IN && REG_ADDR_IN == LINE_ONE_ADDR;
  assign wr_two = REG_WR_IN && REG_ADDR_IN == LINE_TWO_ADDR;
  a_rdata_idle_zero: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  a_one_level_connects:
    assert property (wr_one && REG_WDATA_IN[6:3] <= LEVEL_MAX ##1 !wr_one |=> FIRST_LEFT_LINE_CONNECT_OUT
      && FIRST_LEFT_LINE_ATTEN_OUT == 5'($past(REG_WDATA_IN[6:3], 2)) * 5'h03) else $error("line one level wrong");
  a_two_code_disconnects:
    assert property (wr_two && REG_WDATA_IN[6:3] == LEVEL_DISCONNECT ##1 !wr_two |=>
      !SECOND_LEFT_LINE_CONNECT_OUT && SECOND_LEFT_LINE_ATTEN_OUT == 5'h00) else $error("line two not cut off");
  a_power_follows_bit:
    assert property (wr_one ##1 !wr_one |=> ADC_POWER_UP_OUT == $past(REG_WDATA_IN[POWER_BIT], 2))
    else $error("power bit not applied");
  a_bias_unselected_only:
    assert property (FIRST_LEFT_LINE_BIAS_OUT == (WEAK_BIAS_EN_OUT && !FIRST_LEFT_LINE_CONNECT_OUT))
    else $error("weak bias on selected input");
  a_reserved_reads_zero:
    assert property ($past(REG_RD_IN && REG_ADDR_IN == LINE_TWO_ADDR) |-> REG_RDATA_OUT[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  a_gain_saturates:
    assert property (PGA_GAIN_OUT <= GAIN_MAX) else $error("gain above ceiling");
  a_step_only_on_tick:
    assert property ($past(!GAIN_SETTLED_OUT) && !$past(SAMPLE_TICK_OUT) && !$past(SAMPLE_TICK_OUT, 2)
      |-> $stable(PGA_GAIN_OUT)) else $error("gain moved between ticks");
endmodule
bind left_adc_line_input_control left_adc_line_input_control_monitor u_monitor (.SYS_CLK_IN, .SYS_RST_IN,
  .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .FIRST_LEFT_LINE_CONNECT_OUT,
  .FIRST_LEFT_LINE_ATTEN_OUT, .FIRST_LEFT_LINE_BIAS_OUT, .SECOND_LEFT_LINE_CONNECT_OUT,
  .SECOND_LEFT_LINE_ATTEN_OUT, .ADC_POWER_UP_OUT, .WEAK_BIAS_EN_OUT, .PGA_GAIN_OUT, .GAIN_SETTLED_OUT,
  .SAMPLE_TICK_OUT);

// ### verif/testbench.sv
// self-checking bench for the left line-input register bank
// assumes the design package and one 100 MHz clock
`timescale 1ns/1ps
module testbench;
  import line_input_ctrl_pkg::*;
  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
  logic SYS_CLK_IN = 1'b0;
  logic SYS_RST_IN = 1'b1;
  logic [7:0] REG_ADDR_IN = 8'h00;
  logic [7:0] REG_WDATA_IN = 8'h00;
  logic REG_WR_IN = 1'b0;
  logic REG_RD_IN = 1'b0;
  logic [7:0] REG_RDATA_OUT;
  logic FIRST_LEFT_LINE_DIFF_OUT, FIRST_LEFT_LINE_CONNECT_OUT, FIRST_LEFT_LINE_BIAS_OUT;
  logic SECOND_LEFT_LINE_DIFF_OUT, SECOND_LEFT_LINE_CONNECT_OUT, SECOND_LEFT_LINE_BIAS_OUT;
  logic [4:0] FIRST_LEFT_LINE_ATTEN_OUT, SECOND_LEFT_LINE_ATTEN_OUT;
  logic ADC_POWER_UP_OUT, WEAK_BIAS_EN_OUT, GAIN_SETTLED_OUT, SAMPLE_TICK_OUT;
  logic [6:0] PGA_GAIN_OUT;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic rd_d = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 84;
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  left_adc_line_input_control u_left_adc_line_input_control (.SYS_CLK_IN, .SYS_RST_IN, .REG_ADDR_IN,
    .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .FIRST_LEFT_LINE_DIFF_OUT,
    .FIRST_LEFT_LINE_CONNECT_OUT, .FIRST_LEFT_LINE_ATTEN_OUT, .FIRST_LEFT_LINE_BIAS_OUT,
    .SECOND_LEFT_LINE_DIFF_OUT, .SECOND_LEFT_LINE_CONNECT_OUT, .SECOND_LEFT_LINE_ATTEN_OUT,
    .SECOND_LEFT_LINE_BIAS_OUT, .ADC_POWER_UP_OUT, .WEAK_BIAS_EN_OUT, .PGA_GAIN_OUT, .GAIN_SETTLED_OUT,
    .SAMPLE_TICK_OUT);
  // read data stands only in the cycle after the strobe
  always @(posedge SYS_CLK_IN) rd_d <= REG_RD_IN;
  always @(negedge SYS_CLK_IN)
    if (rd_d)
    begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, REG_RDATA_OUT)
    end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK_IN);
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    REG_WR_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge SYS_CLK_IN);
    REG_ADDR_IN <= a;
    REG_RD_IN <= 1'b1;
    exp_q.push_back(e);
    @(posedge SYS_CLK_IN);
    REG_RD_IN <= 1'b0;
  endtask
  // bounded so a dead divider cannot hang the run
  task automatic wait_ticks(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge SYS_CLK_IN);
        k++;
      end while (SAMPLE_TICK_OUT !== 1'b1 && k < 3000);
    end
    repeat (3) @(posedge SYS_CLK_IN);
    @(negedge SYS_CLK_IN);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #400_000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    logic [7:0] d;
    logic [3:0] c;
    logic [4:0] at;
    repeat (8) @(posedge SYS_CLK_IN);
    SYS_RST_IN <= 1'b0;
    rd_reg(LINE_ONE_ADDR, LINE_ONE_RST);
    rd_reg(LINE_TWO_ADDR, LINE_TWO_RST);
    rd_reg(8'h55, 8'h00);
    // every legal level code plus disconnect, random mode bits
    for (int i = 0; i < 10; i++)
    begin
      c = (i == 9) ? LEVEL_DISCONNECT : 4'(i);
      at = (i == 9) ? 5'h00 : 5'(c) * 5'h03;
      d = 8'($random(seed));
      wr_reg(LINE_ONE_ADDR, {d[7], c, d[2], 2'h3});
      wr_reg(LINE_TWO_ADDR, {d[6], c, d[5], 2'h0});
      rd_reg(LINE_TWO_ADDR, {d[6], c, d[5], 2'h0});
      @(negedge SYS_CLK_IN);
      `CHK("diff1", d[7], FIRST_LEFT_LINE_DIFF_OUT)
      `CHK("line1", {i != 9, at}, {FIRST_LEFT_LINE_CONNECT_OUT, FIRST_LEFT_LINE_ATTEN_OUT})
      `CHK("power", d[2], ADC_POWER_UP_OUT)
      `CHK("diff2", d[6], SECOND_LEFT_LINE_DIFF_OUT)
      `CHK("line2", {i != 9, at}, {SECOND_LEFT_LINE_CONNECT_OUT, SECOND_LEFT_LINE_ATTEN_OUT})
      `CHK("bias1", {d[5], d[5] && i == 9}, {WEAK_BIAS_EN_OUT, FIRST_LEFT_LINE_BIAS_OUT})
      `CHK("bias2", d[5] && i == 9, SECOND_LEFT_LINE_BIAS_OUT)
    end
    wr_reg(LINE_ONE_ADDR, 8'h7F);
    wr_reg(GAIN_TARGET_ADDR, 8'hFF);
    rd_reg(GAIN_TARGET_ADDR, {1'b0, GAIN_MAX});
    @(negedge SYS_CLK_IN);
    `CHK("jump", GAIN_MAX, PGA_GAIN_OUT)
    wr_reg(LINE_ONE_ADDR, 8'h7C);
    wr_reg(GAIN_TARGET_ADDR, 8'h74);
    repeat (2) @(posedge SYS_CLK_IN);
    @(negedge SYS_CLK_IN);
    `CHK("settled", 1'b0, GAIN_SETTLED_OUT)
    wait_ticks(2);
    `CHK("every1", 7'h75, PGA_GAIN_OUT)
    wait_ticks(1);
    `CHK("done1", {1'b1, 7'h74}, {GAIN_SETTLED_OUT, PGA_GAIN_OUT})
    wr_reg(LINE_ONE_ADDR, 8'h7D);
    wr_reg(GAIN_TARGET_ADDR, 8'h76);
    wait_ticks(2);
    `CHK("every2", 7'h75, PGA_GAIN_OUT)
    wait_ticks(2);
    `CHK("done2", 7'h76, PGA_GAIN_OUT)
    rd_reg(GAIN_STATUS_ADDR, {1'b1, 7'h76});
    rd_reg(FLAG_ADDR, 8'h00);
    repeat (3) @(posedge SYS_CLK_IN);
    finish_test();
  end
endmodule
